// [dv/apsq_checker.sv]
// assertions on the link between controller and power stage
`timescale 1ns/10ps
module apsq_checker
  import apsq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic [3:0] pwm_in,
  input wire logic fault_oe,
  input wire logic gate_drive_supply_ok,
  input wire logic common_supply_ok,
  input wire logic [3:0] bootstrap_node_uv,
  input wire logic [3:0] channel_fault,
  input wire logic overtemp_shutdown,
  input wire apsq_mode_t out_mode,
  input wire logic [3:0] unused_mask,
  input wire logic streaming,
  input wire logic [3:0] high_side_on,
  input wire logic [3:0] low_side_on,
  input wire logic ramp_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_flag_quiet: assert property (!reset_n |=> !fault_oe)
    else $error("fault flag driven while reset low");
  a_flag_on: assert property (reset_n && |channel_fault |=> fault_oe)
    else $error("fault flag not driven");
  a_pair_ab: assert property (
    |channel_fault[1:0] |=> (high_side_on[1:0] | low_side_on[1:0]) == 2'h0)
    else $error("pair a b still switching");
  a_pair_all: assert property (
    out_mode == 2'h2 && |channel_fault |=> (high_side_on | low_side_on) == 0)
    else $error("parallel mode still switching");
  a_supply_hiz: assert property (
    !(gate_drive_supply_ok && common_supply_ok) |=>
    (high_side_on | low_side_on) == 4'h0)
    else $error("switching with low supply");
  a_boot_hs: assert property (
    |bootstrap_node_uv |=> (high_side_on & $past(bootstrap_node_uv)) == 0)
    else $error("high side on with bootstrap low");
  a_gate_follow: assert property (
    (high_side_on & ~$past(pwm_in)) == 4'h0 && (high_side_on & low_side_on) == 0)
    else $error("gates do not follow input");
  a_unused_low: assert property ((pwm_in & unused_mask) == 4'h0)
    else $error("unused input not grounded");
  a_idle_half: assert property (
    $rose(pwm_in[0]) && !streaming ##2 !streaming |-> !pwm_in[0])
    else $error("idle input not square");
  a_latch_hold: assert property (
    overtemp_shutdown ##1 reset_n[*4] |-> (high_side_on | low_side_on) == 0)
    else $error("overtemp latch lost");
  c_ramp: cover property ($rose(ramp_done));
  c_par: cover property (out_mode == 2'h2 && |channel_fault);
  c_latch: cover property (overtemp_shutdown && reset_n);
endmodule : apsq_checker

// [dv/tb.sv]
// testbench joining controller and power stage ends
`timescale 1ns/10ps
module tb;
  import apsq_pkg::*;
  // short ms count keeps the ramps to a few hundred cycles
  localparam int CYC = 2;
  localparam int RAMP = (100 + 4) * CYC;
  typedef struct {string n; logic [15:0] m; logic [15:0] e;} apsq_note_t;
  logic mclk;
  logic rst = 1'b1;
  logic gate_drive_supply_ok = 1'b0, common_supply_ok = 1'b1;
  logic overload = 1'b0, overtemp_shutdown = 1'b0;
  logic supplies_settled = 1'b0, run_req = 1'b0;
  logic [3:0] bootstrap_node_uv = 4'h0, channel_fault = 4'h0;
  logic [3:0] unused_mask = 4'h8, pwm_data = 4'h0;
  logic [15:0] ramp_timing_cap = 16'h0004;
  apsq_mode_t out_mode = 2'h0;
  logic [3:0] high_side_on, low_side_on, weak_pulldown;
  logic ramp_busy, ramp_done, fault_pin_seen, streaming, fault_seen;
  int error_cnt = 0, comparisons = 0;
  int unsigned seed = 48;
  apsq_note_t notes[$];
  event look;
  wire [15:0] obs = {high_side_on, low_side_on, weak_pulldown, ramp_busy,
    ramp_done, fault_pin_seen, fault_seen};
  apsq_if pif();
  apsq_ctrl #(.CYC_PER_MS(CYC), .IDLE_HALF(2)) u_apsq_ctrl (.mclk, .rst,
    .pins(pif.host), .supplies_settled, .run_req, .unused_mask, .pwm_data,
    .ramp_timing_cap, .streaming, .fault_seen);
  apsq_stage #(.CYC_PER_MS(CYC)) u_apsq_stage (.mclk, .rst, .pins(pif.dev),
    .gate_drive_supply_ok, .common_supply_ok, .bootstrap_node_uv,
    .channel_fault, .overload, .overtemp_shutdown, .out_mode,
    .ramp_timing_cap, .high_side_on, .low_side_on, .weak_pulldown,
    .ramp_busy, .ramp_done, .fault_pin_seen);
  apsq_checker u_apsq_checker (.mclk, .rst, .reset_n(pif.reset_n),
    .pwm_in(pif.pwm_in), .fault_oe(pif.fault_oe), .gate_drive_supply_ok,
    .common_supply_ok, .bootstrap_node_uv, .channel_fault, .overtemp_shutdown,
    .out_mode, .unused_mask, .streaming, .high_side_on, .low_side_on,
    .ramp_done);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [3:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[3:0];
  endfunction : xs
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task automatic note(string n, logic [15:0] m, logic [15:0] e);
    notes.push_back('{n, m, e});
    -> look;
  endtask : note
  // waits for a ramp to start, then counts its cycles
  task automatic ramp_len(string n);
    int k;
    k = 0;
    while (ramp_busy !== 1'b1 && k < 2000) begin
      cyc(1);
      k++;
    end
    k = 0;
    while (ramp_busy === 1'b1 && k < 2000) begin
      cyc(1);
      k++;
    end
    cmp(n, RAMP[15:0], k[15:0]);
  endtask : ramp_len
  task automatic tally_and_finish();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  always begin
    apsq_note_t t;
    @(look);
    while (notes.size() > 0) begin
      t = notes.pop_front();
      cmp(t.n, t.e, obs & t.m);
    end
  end
  initial begin
    #50000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] g;
    cyc(12);
    rst = 1'b0;
    channel_fault = 4'h1;
    cyc(3);
    note("hold", 16'h00F3, 16'h00F0);
    channel_fault = 4'h0;
    run_req = 1'b1;
    cyc(6);
    // reset must stay low until the controller sees settled supplies
    note("wait_settle", 16'h00F0, 16'h00F0);
    supplies_settled = 1'b1;
    cyc(20);
    note("no_supply", 16'hFF08, 16'h0000);
    gate_drive_supply_ok = 1'b1;
    ramp_len("up_ramp");
    note("run", 16'h000C, 16'h0004);
    cmp("streaming", 16'h0001, {15'h0000, streaming});
    for (int i = 0; i < 8; i++) begin
      pwm_data = xs();
      cyc(3);
      note("follow", 16'hFF00, {pwm_data & 4'h7, ~(pwm_data & 4'h7), 8'h00});
    end
    // common supply dip: hi-z at once, then a full new up ramp
    common_supply_ok = 1'b0;
    cyc(3);
    note("uv", 16'hFF0E, 16'h0002);
    common_supply_ok = 1'b1;
    ramp_len("uv_restart");
    pwm_data = 4'h5;
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 4; c += 2) begin
        out_mode = apsq_mode_t'(m);
        channel_fault = 4'h1 << c;
        cyc(3);
        g = (m == 2) ? 8'h00 : ((c == 0) ? 8'h48 : 8'h12);
        note("group", 16'hFF02, {g, 8'h02});
        channel_fault = 4'h0;
        cyc(3);
        note("recover", 16'hFF02, 16'h5A00);
      end
    end
    out_mode = 2'h0;
    pwm_data = 4'h7;
    bootstrap_node_uv = 4'h2;
    cyc(3);
    note("boot", 16'hFF00, 16'h5800);
    bootstrap_node_uv = 4'h0;
    overtemp_shutdown = 1'b1;
    cyc(1);
    overtemp_shutdown = 1'b0;
    cyc(5);
    note("latch", 16'hFF0B, 16'h0003);
    run_req = 1'b0;
    cyc(4);
    note("release", 16'h0003, 16'h0000);
    cmp("streaming_off", 16'h0000, {15'h0000, streaming});
    run_req = 1'b1;
    ramp_len("restart");
    // overload latches like overtemperature, cleared only by reset low
    overload = 1'b1;
    cyc(1);
    overload = 1'b0;
    cyc(5);
    note("ol_latch", 16'hFF0B, 16'h0003);
    run_req = 1'b0;
    cyc(4);
    note("ol_release", 16'h0003, 16'h0000);
    run_req = 1'b1;
    ramp_len("ol_restart");
    run_req = 1'b0;
    ramp_len("down_ramp");
    cyc(2);
    note("off", 16'hFFFC, 16'h00F0);
    cyc(2);
    tally_and_finish();
  end
endmodule : tb

// [logic/apsq_ctrl.sv]
// controller end: reset sequencing and idle pwm around the ramps
`timescale 1ns/10ps
`include "apsq_defines.svh"
module apsq_ctrl
  import apsq_pkg::*;
#(
  parameter int CYC_PER_MS = `APSQ_CYC_PER_MS,
  parameter int IDLE_HALF = `APSQ_IDLE_HALF_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  apsq_if.host pins,
  input wire logic supplies_settled,
  input wire logic run_req,
  input wire logic [3:0] unused_mask,
  input wire logic [3:0] pwm_data,
  input wire logic [15:0] ramp_timing_cap,
  output logic streaming,
  output logic fault_seen
);

  generate
    if (CYC_PER_MS < 2 || IDLE_HALF < 1) begin : g_bad_par
      $error("CYC_PER_MS must be >= 2 and IDLE_HALF >= 1");
    end
  endgenerate

  localparam int DIV_W = $clog2(CYC_PER_MS);
  localparam int IH_W = $clog2(IDLE_HALF + 1);

  apsq_hstate_t st_r, st_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [16:0] ms_r, ms_nxt;
  logic [IH_W-1:0] ih_r, ih_nxt;
  logic idle_r, idle_nxt;
  logic rn_r, rn_nxt;
  logic [3:0] pwm_r, pwm_nxt;
  logic str_r, fs_r;
  logic tick;
  logic go;

  assign tick = (div_r == DIV_W'(CYC_PER_MS - 1));
  assign go = run_req && supplies_settled;

  always_comb begin
    st_nxt = st_r;
    div_nxt = tick ? '0 : div_r + DIV_W'(1);
    ms_nxt = ms_r;
    rn_nxt = rn_r;
    // square idle pwm, 50 percent duty, muted audio
    ih_nxt = (ih_r == IH_W'(IDLE_HALF - 1)) ? '0 : ih_r + IH_W'(1);
    idle_nxt = (ih_r == IH_W'(IDLE_HALF - 1)) ? !idle_r : idle_r;
    case (st_r)
      APSQ_H_HOLD: begin
        div_nxt = '0;
        rn_nxt = 1'b0;
        if (go) begin
          st_nxt = APSQ_H_UP;
          rn_nxt = 1'b1;
          ms_nxt = 17'(`APSQ_RAMP_BASE_MS) + {1'b0, ramp_timing_cap};
        end
      end
      APSQ_H_UP, APSQ_H_DOWN: begin
        if (st_r == APSQ_H_UP && !go) begin
          st_nxt = APSQ_H_DOWN;
          rn_nxt = 1'b0;
          div_nxt = '0;
          ms_nxt = 17'(`APSQ_RAMP_BASE_MS) + {1'b0, ramp_timing_cap};
        end else if (tick) begin
          ms_nxt = ms_r - 17'h1;
          if (ms_r == 17'h1) begin
            st_nxt = (st_r == APSQ_H_UP) ? APSQ_H_RUN : APSQ_H_HOLD;
          end
        end
      end
      APSQ_H_RUN: begin
        div_nxt = '0;
        if (!go) begin
          st_nxt = APSQ_H_DOWN;
          rn_nxt = 1'b0;
          ms_nxt = 17'(`APSQ_RAMP_BASE_MS) + {1'b0, ramp_timing_cap};
        end
      end
      default: begin
        st_nxt = APSQ_H_HOLD;
      end
    endcase
    pwm_nxt = (st_nxt == APSQ_H_RUN) ? pwm_data : {4{idle_nxt}};
    pwm_nxt = pwm_nxt & ~unused_mask;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= APSQ_H_HOLD;
      div_r <= '0;
      ms_r <= 17'h0;
      ih_r <= '0;
      idle_r <= 1'b0;
      rn_r <= `APSQ_RST_N_RST;
      pwm_r <= `APSQ_CH_RST;
      str_r <= 1'b0;
      fs_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      ms_r <= ms_nxt;
      ih_r <= ih_nxt;
      idle_r <= idle_nxt;
      rn_r <= rn_nxt;
      pwm_r <= pwm_nxt;
      str_r <= (st_nxt == APSQ_H_RUN);
      fs_r <= !pins.fault_lvl;
    end
  end

  assign pins.reset_n = rn_r;
  assign pins.pwm_in = pwm_r;
  assign streaming = str_r;
  assign fault_seen = fs_r;

endmodule : apsq_ctrl

// [logic/apsq_defines.svh]
// timing counts, reset values and mode codes for the power stage sequencer
`ifndef APSQ_DEFINES_SVH
`define APSQ_DEFINES_SVH
`define APSQ_CLK_HZ 200000000
`define APSQ_MS_PER_S 1000
`define APSQ_CYC_PER_MS (`APSQ_CLK_HZ / `APSQ_MS_PER_S)
`define APSQ_RAMP_BASE_MS 100
`define APSQ_RAMP_CAP_NF 100
`define APSQ_IDLE_PWM_HZ 384000
`define APSQ_IDLE_HALF_CYC (`APSQ_CLK_HZ / (2 * `APSQ_IDLE_PWM_HZ))
`define APSQ_MODE_BRIDGED 2'h0
`define APSQ_MODE_SINGLE 2'h1
`define APSQ_MODE_PARALLEL 2'h2
`define APSQ_CH_RST 4'h0
`define APSQ_RST_N_RST 1'b0
`endif

// [logic/apsq_if.sv]
// pins between the pwm/system controller and the power stage
`timescale 1ns/10ps
interface apsq_if;
  logic reset_n;
  logic [3:0] pwm_in;
  logic fault_o;
  logic fault_oe;
  logic fault_lvl;
  // open-drain flag with pullup: low only while the stage drives low
  assign fault_lvl = fault_oe ? fault_o : 1'b1;
  modport dev (input reset_n, input pwm_in, output fault_o,
    output fault_oe, input fault_lvl);
  modport host (output reset_n, output pwm_in, input fault_lvl);
endinterface : apsq_if

// [logic/apsq_pkg.sv]
// types shared by both ends of the power stage sequencer
`include "apsq_defines.svh"
package apsq_pkg;
  typedef enum logic [1:0] {
    APSQ_S_OFF  = 2'b00,
    APSQ_S_UP   = 2'b01,
    APSQ_S_RUN  = 2'b10,
    APSQ_S_DOWN = 2'b11
  } apsq_state_t;
  typedef enum logic [1:0] {
    APSQ_H_HOLD = 2'b00,
    APSQ_H_UP   = 2'b01,
    APSQ_H_RUN  = 2'b10,
    APSQ_H_DOWN = 2'b11
  } apsq_hstate_t;
  typedef logic [1:0] apsq_mode_t;
endpackage : apsq_pkg

// [logic/apsq_stage.sv]
// power stage end: supply guard, start/stop ramp, fault shutdown
// Functional notes
// - outputs hi-z until both supplies pass guard
// - weak pulldown on outputs while reset low and the stage is off
// - fully operational while both supplies stay good and no fault is latched
// - no supply order needed, no turn-on
// - controller releases reset only after supplies settle
// - ramp lasts 100 ms plus cap nanofarads
// - pwm source sends idle pwm during ramps; controller keeps streaming pwm_data during the stage ramp after a supply dip
// - ramp input is muted 50 percent duty
// - unused channel input grounded, output may float
// - any fault but bootstrap undervoltage: hi-z stage or its group, fault flag low
// - non-latched faults clear by themselves
// - fault groups: AB/CD, or all in parallel
// - bootstrap undervoltage kills only that high side
// - controller holds reset low while powering down
// - reset low forces fault flag released high
// - overtemperature latched until reset asserted
`timescale 1ns/10ps
`include "apsq_defines.svh"
module apsq_stage
  import apsq_pkg::*;
#(
  parameter int CYC_PER_MS = `APSQ_CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic rst,
  apsq_if.dev pins,
  input wire logic gate_drive_supply_ok,
  input wire logic common_supply_ok,
  input wire logic [3:0] bootstrap_node_uv,
  input wire logic [3:0] channel_fault,
  input wire logic overload,
  input wire logic overtemp_shutdown,
  input wire apsq_mode_t out_mode,
  input wire logic [15:0] ramp_timing_cap,
  output logic [3:0] high_side_on,
  output logic [3:0] low_side_on,
  output logic [3:0] weak_pulldown,
  output logic ramp_busy,
  output logic ramp_done,
  output logic fault_pin_seen
);

  generate
    if (CYC_PER_MS < 2) begin : g_bad_div
      $error("CYC_PER_MS must be at least 2");
    end
  endgenerate

  localparam int DIV_W = $clog2(CYC_PER_MS);

  // shutdown mask of channels for the current output configuration
  function automatic logic [3:0] grp_mask(input apsq_mode_t m,
                                          input logic [3:0] f);
    logic [3:0] r;
    r = 4'h0;
    if (m == `APSQ_MODE_PARALLEL) begin
      r = {4{|f}};
    end else begin
      r[1:0] = {2{|f[1:0]}};
      r[3:2] = {2{|f[3:2]}};
    end
    return r;
  endfunction : grp_mask

  apsq_state_t state_r, state_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [16:0] ms_r, ms_nxt;
  logic done_r, done_nxt;
  logic ot_r, ot_nxt;
  logic ol_r, ol_nxt;
  logic [3:0] hs_r, hs_nxt;
  logic [3:0] ls_r, ls_nxt;
  logic [3:0] pd_r, pd_nxt;
  logic oe_r, oe_nxt;
  logic busy_r, busy_nxt;
  logic seen_r;

  logic rst_low;
  logic supplies_ok;
  logic global_kill;
  logic tick;
  logic [16:0] ramp_len;
  logic [3:0] ch_en;

  assign rst_low = !pins.reset_n;
  assign supplies_ok = gate_drive_supply_ok && common_supply_ok;
  assign global_kill = !supplies_ok || ot_r || ol_r;
  assign tick = (div_r == DIV_W'(CYC_PER_MS - 1));
  assign ramp_len = 17'(`APSQ_RAMP_BASE_MS) + {1'b0, ramp_timing_cap};

  // sequencer and ramp timer
  always_comb begin
    state_nxt = state_r;
    div_nxt = tick ? '0 : div_r + DIV_W'(1);
    ms_nxt = ms_r;
    done_nxt = done_r;
    case (state_r)
      APSQ_S_OFF: begin
        div_nxt = '0;
        done_nxt = 1'b0;
        // leaving off needs a released reset; supplies alone never start it
        if (!rst_low && !global_kill) begin
          state_nxt = APSQ_S_UP;
          ms_nxt = ramp_len;
        end
      end
      APSQ_S_UP: begin
        if (global_kill) begin
          state_nxt = APSQ_S_OFF;
        end else if (rst_low) begin
          state_nxt = APSQ_S_DOWN;
          ms_nxt = ramp_len;
          div_nxt = '0;
        end else if (tick) begin
          ms_nxt = ms_r - 17'h1;
          if (ms_r == 17'h1) begin
            state_nxt = APSQ_S_RUN;
            done_nxt = 1'b1;
          end
        end
      end
      APSQ_S_RUN: begin
        div_nxt = '0;
        // stays switching as long as both supplies hold and no overtemp or overload is latched
        if (global_kill) begin
          state_nxt = APSQ_S_OFF;
          done_nxt = 1'b0;
        end else if (rst_low) begin
          state_nxt = APSQ_S_DOWN;
          ms_nxt = ramp_len;
          done_nxt = 1'b0;
        end
      end
      APSQ_S_DOWN: begin
        // a release mid-ramp finishes the shutdown first, then restarts
        if (global_kill) begin
          state_nxt = APSQ_S_OFF;
        end else if (tick) begin
          ms_nxt = ms_r - 17'h1;
          if (ms_r == 17'h1) begin
            state_nxt = APSQ_S_OFF;
          end
        end
      end
      default: begin
        state_nxt = APSQ_S_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= APSQ_S_OFF;
      div_r <= '0;
      ms_r <= 17'h0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      ms_r <= ms_nxt;
      done_r <= done_nxt;
    end
  end

  // fault latches and output stage
  always_comb begin
    // set wins over the clear by reset
    ot_nxt = overtemp_shutdown || (ot_r && !rst_low);
    ol_nxt = overload || (ol_r && !rst_low);
    ch_en = (state_r != APSQ_S_OFF && !global_kill) ?
            ~grp_mask(out_mode, channel_fault) : 4'h0;
    // outputs follow the input pwm, ramps included
    hs_nxt = ch_en & pins.pwm_in & ~bootstrap_node_uv;
    ls_nxt = ch_en & ~pins.pwm_in;
    pd_nxt = {4{rst_low && state_r == APSQ_S_OFF}};
    oe_nxt = !rst_low && (global_kill || (|channel_fault));
    busy_nxt = (state_nxt == APSQ_S_UP) || (state_nxt == APSQ_S_DOWN);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ot_r <= 1'b0;
      ol_r <= 1'b0;
      hs_r <= `APSQ_CH_RST;
      ls_r <= `APSQ_CH_RST;
      pd_r <= `APSQ_CH_RST;
      oe_r <= 1'b0;
      busy_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      ot_r <= ot_nxt;
      ol_r <= ol_nxt;
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
      pd_r <= pd_nxt;
      oe_r <= oe_nxt;
      busy_r <= busy_nxt;
      seen_r <= !pins.fault_lvl;
    end
  end

  assign pins.fault_o = 1'b0;
  assign pins.fault_oe = oe_r;
  assign high_side_on = hs_r;
  assign low_side_on = ls_r;
  assign weak_pulldown = pd_r;
  assign ramp_busy = busy_r;
  assign ramp_done = done_r;
  assign fault_pin_seen = seen_r;

endmodule : apsq_stage
